// [pwm_pdm_sensor_output.sv]
`include "pwm_pdm_defines.svh"

module pwm_pdm_sensor_output
   import pwm_pdm_pkg::*;
#(
   parameter int MEAS_CYCLES = `MEAS_CYCLES,
   parameter int SLOT_CYCLES = `SLOT_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // pins from outside
   input wire logic [1:0] fmtSelPin,
   input wire logic sclPin,
   // measurement core
   output logic measStart,
   input wire meas_s measResult,
   input wire logic measValid,
   // data pin
   output logic sdaOut,
   output logic sdaOe
);

   localparam int SW = `SLOT_LOG2;

   // reset release and pin synchronisers
   logic rstMeta_q, rstSync_q;
   logic [1:0] fmtMeta_q, fmtSync_q;
   logic sclMeta_q, sclSync_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         fmtMeta_q <= 2'h0;
         fmtSync_q <= 2'h0;
         sclMeta_q <= 1'b0;
         sclSync_q <= 1'b0;
      end else begin
         fmtMeta_q <= fmtSelPin;
         fmtSync_q <= fmtMeta_q;
         sclMeta_q <= sclPin;
         sclSync_q <= sclMeta_q;
      end
   end

   // mode decode; analogue and unused codes leave the pin released
   out_mode_e mode;
   assign mode = (fmtSync_q == `FMT_PWM) ? OUT_PWM :
                 (fmtSync_q == `FMT_PDM) ? OUT_PDM : OUT_OFF;
   wire standAlone = (mode != OUT_OFF);

   // measurement pacing
   logic [31:0] measCnt_q, measCnt_d;
   logic measStart_q, measStart_d;
   assign measCnt_d = !standAlone ? 32'h0 :
                      (measCnt_q == 32'(MEAS_CYCLES - 1)) ? 32'h0 : measCnt_q + 32'h1;
   assign measStart_d = standAlone && (measCnt_q == 32'h0);

   always_ff @(posedge ref_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         measCnt_q <= 32'h0;
         measStart_q <= 1'b0;
      end else begin
         measCnt_q <= measCnt_d;
         measStart_q <= measStart_d;
      end
   end

   // latest result, truncated to output resolution; status bits fall below the cut
   result_s res_q;
   always_ff @(posedge ref_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         res_q <= '0;
      end else if (measValid) begin
         res_q.humCode <= measResult.humRaw[`RAW_MSB:`RH_LSB];
         res_q.tempCode <= measResult.tempRaw[`RAW_MSB:`T_LSB];
      end
   end

   // frame timing: 4096 slots of SLOT_CYCLES each, about 120 Hz
   logic [15:0] slotDiv_q;
   logic [SW-1:0] slotCnt_q;
   wire tickEn = (slotDiv_q == 16'(SLOT_CYCLES - 1));
   wire frameEnd = tickEn && (slotCnt_q == {SW{1'b1}});
   wire [15:0] slotDiv_d = tickEn ? 16'h0 : slotDiv_q + 16'h1;
   wire [SW-1:0] slotCnt_d = tickEn ? slotCnt_q + 1'b1 : slotCnt_q;

   always_ff @(posedge ref_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         slotDiv_q <= 16'h0;
         slotCnt_q <= '0;
      end else begin
         slotDiv_q <= slotDiv_d;
         slotCnt_q <= slotCnt_d;
      end
   end

   // output code, humidity scaled to 12 bits so both share one full scale
   logic [SW-1:0] duty_q;
   wire [SW-1:0] humScaled = {res_q.humCode, 2'h0};
   wire [SW-1:0] nextDuty = sclSync_q ? humScaled : res_q.tempCode;

   always_ff @(posedge ref_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         duty_q <= '0;
      end else if (frameEnd) begin
         duty_q <= nextDuty;
      end
   end

   // pulse-density modulator on the full clock rate for low ripple after filtering
   logic pdmPulse;
   pdm_accumulator #(.W(SW)) u_pdm_accumulator (
      .clk(ref_clk),
      .rstSync_b(rstSync_q),
      .enable(mode == OUT_PDM),
      .increment(duty_q),
      .pulse(pdmPulse)
   );

   // data pin: compare yields high time = duty/4096 of the frame
   // the frame's first slot is launched in the boundary cycle, so it must see the incoming code
   wire pwmBit = frameEnd ? (nextDuty != '0) : (slotCnt_d < duty_q);
   logic sdaOut_q, sdaOe_q;
   wire sdaOut_d = (mode == OUT_PWM) ? pwmBit :
                   (mode == OUT_PDM) ? pdmPulse : 1'b0;

   always_ff @(posedge ref_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         sdaOut_q <= 1'b0;
         sdaOe_q <= 1'b0;
      end else begin
         sdaOut_q <= sdaOut_d;
         sdaOe_q <= standAlone;
      end
   end

   assign measStart = measStart_q;
   assign sdaOut = sdaOut_q;
   assign sdaOe = sdaOe_q;

   property p_hum_load;
      @(posedge ref_clk) disable iff (!rstSync_q)
      frameEnd && sclSync_q |=> duty_q == {$past(res_q.humCode), 2'h0};
   endproperty
   a_hum_load: assert property (p_hum_load) else $error("humidity code not loaded");

   property p_temp_load;
      @(posedge ref_clk) disable iff (!rstSync_q)
      frameEnd && !sclSync_q |=> duty_q == $past(res_q.tempCode);
   endproperty
   a_temp_load: assert property (p_temp_load) else $error("temperature code not loaded");

   property p_code_hold;
      @(posedge ref_clk) disable iff (!rstSync_q)
      !frameEnd |=> $stable(duty_q);
   endproperty
   a_code_hold: assert property (p_code_hold) else $error("code changed inside frame");

   property p_result_latch;
      @(posedge ref_clk) disable iff (!rstSync_q)
      measValid |=> res_q.humCode == $past(measResult.humRaw[15:6])
                    && res_q.tempCode == $past(measResult.tempRaw[15:4]);
   endproperty
   a_result_latch: assert property (p_result_latch) else $error("result not captured");

   property p_meas_gap;
      @(posedge ref_clk) disable iff (!rstSync_q)
      measStart_q |=> !measStart_q [*8];
   endproperty
   a_meas_gap: assert property (p_meas_gap) else $error("measurement starts too close");

   property p_pwm_fall;
      @(posedge ref_clk) disable iff (!rstSync_q)
      mode == OUT_PWM && tickEn && slotCnt_d == duty_q && !frameEnd |=> !sdaOut_q;
   endproperty
   a_pwm_fall: assert property (p_pwm_fall) else $error("pwm high past duty");

   property p_pwm_rise;
      @(posedge ref_clk) disable iff (!rstSync_q)
      mode == OUT_PWM && frameEnd && nextDuty != '0 |=> sdaOut_q;
   endproperty
   a_pwm_rise: assert property (p_pwm_rise) else $error("pwm frame did not start high");

   property p_pdm_drive;
      @(posedge ref_clk) disable iff (!rstSync_q)
      mode == OUT_PDM |=> sdaOe_q && sdaOut_q == $past(pdmPulse);
   endproperty
   a_pdm_drive: assert property (p_pdm_drive) else $error("pdm stream not on data pin");

   property p_off_release;
      @(posedge ref_clk) disable iff (!rstSync_q)
      !standAlone |=> !sdaOe_q && !measStart_q;
   endproperty
   a_off_release: assert property (p_off_release) else $error("active outside stand-alone");

endmodule // pwm_pdm_sensor_output

// [pwm_pdm_defines.svh]
`ifndef PWM_PDM_DEFINES_SVH
`define PWM_PDM_DEFINES_SVH

// reference clock and derived timing
`define CLK_HZ 40000000
`define FRAME_HZ 120
`define MEAS_PER_SEC 2
`define SLOT_LOG2 12
`define SLOTS_PER_FRAME 4096
// longest slot that still keeps the frame at or above the base rate, rounded down
`define SLOT_CYCLES ((`CLK_HZ) / ((`FRAME_HZ) * (`SLOTS_PER_FRAME)))
`define MEAS_CYCLES ((`CLK_HZ) / (`MEAS_PER_SEC))

// output format selection codes
`define FMT_PWM 2'h1
`define FMT_PDM 2'h2

// result field positions in the 16-bit raw word
`define RAW_MSB 15
`define RH_BITS 10
`define T_BITS 12
`define RH_LSB 6
`define T_LSB 4

`endif

// [pwm_pdm_pkg.sv]
package pwm_pdm_pkg;

   typedef enum logic [1:0] {
      OUT_OFF,
      OUT_PWM,
      OUT_PDM
   } out_mode_e;

   typedef struct packed {
      logic [15:0] humRaw;
      logic [15:0] tempRaw;
   } meas_s;

   typedef struct packed {
      logic [9:0] humCode;
      logic [11:0] tempCode;
   } result_s;

endpackage

// [pdm_accumulator.sv]
`include "pwm_pdm_defines.svh"

module pdm_accumulator
   import pwm_pdm_pkg::*;
#(
   parameter int W = 12
) (
   // clock and synchronised reset
   input wire logic clk,
   input wire logic rstSync_b,
   // modulator
   input wire logic enable,
   input wire logic [W-1:0] increment,
   output logic pulse
);

   logic [W-1:0] acc_q;
   logic pulse_q;
   wire [W:0] sum = {1'b0, acc_q} + {1'b0, increment};

   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         acc_q <= '0;
         pulse_q <= 1'b0;
      end else if (enable) begin
         acc_q <= sum[W-1:0];
         pulse_q <= sum[W];
      end else begin
         pulse_q <= 1'b0;
      end
   end

   assign pulse = pulse_q;

   property p_zero_silent;
      @(posedge clk) disable iff (!rstSync_b)
      (enable && increment == '0) [*2] |=> !pulse_q;
   endproperty
   a_zero_silent: assert property (p_zero_silent) else $error("pdm pulse with zero code");

   // half scale must toggle every cycle once settled
   property p_half_toggle;
      @(posedge clk) disable iff (!rstSync_b)
      (enable && increment == {1'b1, {(W-1){1'b0}}}) [*3] |=> (pulse_q != $past(pulse_q));
   endproperty
   a_half_toggle: assert property (p_half_toggle) else $error("pdm half scale not alternating");

endmodule // pdm_accumulator

// [pin_capture.sv]
module pin_capture (
   // clock
   input wire logic clk,
   // data pin from the sensor
   input wire logic sdaOut,
   input wire logic sdaOe,
   // capture control and results
   input wire logic clr,
   output logic [15:0] highs,
   output logic [15:0] period
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pin;
   logic pinLast = 1'b1;
   logic [15:0] sinceRise = 16'h0;
   // pull-up holds the line high while the sensor lets go
   assign pin = sdaOe ? sdaOut : 1'b1;
   initial highs = 16'h0;
   initial period = 16'h0;
   // an rc filter sees only the share of high cycles, so count them
   always @(posedge clk) begin
      pinLast <= pin;
      highs <= clr ? 16'h0 : highs + {15'h0, pin};
      sinceRise <= sinceRise + 16'h1;
      if (pin && !pinLast) begin
         period <= sinceRise;
         sinceRise <= 16'h1;
      end
   end
endmodule // pin_capture

// [tb.sv]
`include "pwm_pdm_defines.svh"

module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import pwm_pdm_pkg::*;
   localparam int MEAS = 300;
   localparam int FRAME = 4096;
   localparam int LIMIT = 60000;
   logic ref_clk, rst_b, sclPin, measValid, measStart, sdaOut, sdaOe, clr;
   logic [1:0] fmtSelPin;
   meas_s measResult, nextMeas;
   logic [15:0] highs, period;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int starts = 0;
   int lastStart = 0;
   int gap = 0;
   int offStarts = 0;

   pwm_pdm_sensor_output #(.MEAS_CYCLES(MEAS), .SLOT_CYCLES(1)) u_pwm_pdm_sensor_output (
      .ref_clk(ref_clk), .rst_b(rst_b), .fmtSelPin(fmtSelPin), .sclPin(sclPin),
      .measStart(measStart), .measResult(measResult), .measValid(measValid),
      .sdaOut(sdaOut), .sdaOe(sdaOe));
   pin_capture u_pin_capture (.clk(ref_clk), .sdaOut(sdaOut), .sdaOe(sdaOe), .clr(clr),
      .highs(highs), .period(period));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task conclude;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // measurement core stand-in: answers each start in the same cycle
   always @(posedge ref_clk) begin
      #1;
      cycles++;
      measValid = measStart;
      measResult = nextMeas;
      if (measStart === 1'b1) begin
         starts++;
         gap = cycles - lastStart;
         lastStart = cycles;
      end
      if (cycles == LIMIT) begin
         num_errors++;
         conclude;
      end
   end

   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // code reaches the pin only at a frame edge, so settle one frame first
   task run(input logic [1:0] fmt, input logic scl, input logic [15:0] h, t);
      logic [15:0] exp;
      exp = scl ? {4'h0, h[15:6], 2'b00} : {4'h0, t[15:4]};
      fmtSelPin = fmt;
      sclPin = scl;
      nextMeas = {h, t};
      cyc(FRAME + 20);
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(FRAME);
      chk(highs, exp);
      chk({15'h0, sdaOe}, 16'h1);
      chk(gap[15:0], 16'(MEAS));
      if (fmt == `FMT_PWM) chk(period, 16'(FRAME));
   endtask

   initial begin
      rst_b = 1'b0;
      fmtSelPin = 2'h0;
      sclPin = 1'b0;
      clr = 1'b0;
      nextMeas = '0;
      cyc(12);
      rst_b = 1'b1;
      cyc(400);
      chk({15'h0, sdaOe}, 16'h0);
      chk(starts[15:0], 16'h0);
      run(`FMT_PWM, 1'b1, 16'h6357, 16'h0);
      run(`FMT_PWM, 1'b0, 16'h0, 16'h6a5c);
      run(`FMT_PDM, 1'b1, 16'h9abc, 16'h0);
      run(`FMT_PDM, 1'b0, 16'h0, 16'h8009);
      run(`FMT_PDM, 1'b0, 16'h0, 16'hfff0);
      run(`FMT_PDM, 1'b0, 16'h0, 16'h000f);
      // code 11 is not a stand-alone format, so the pin is released and pacing stops
      fmtSelPin = 2'h3;
      cyc(8);
      offStarts = starts;
      chk({15'h0, sdaOe}, 16'h0);
      cyc(MEAS + 20);
      chk(starts[15:0], offStarts[15:0]);
      conclude;
   end
endmodule // tb
